/* File: fcld_decoder.sv */
// Purpose: flash command decoder reached over an AHB-Lite register slave
// Assumes: host writes the flash address, then writes the bus data word
// Notes:   reads take one wait state so they see the newest address
// Summary of operation
// - config load: 60h then 03h, value on address
// - config bits from address 0..15 only
// - after config load the bank reads array
// - every block locked after any reset
// - 60h,01h locks block; locked blocks refuse writes
// - 60h,D0h unlocks block, permitting program/erase
// - 60h,2Fh locks down, from either prior state
// - locked-down blocks refuse program and erase while write protect is low
// - write protect low freezes locked-down blocks
// - lock bit set by any reset, cleared only by unlock
// - power-down reset reverts lock-down to locked
// - one write per bank selects its read mode
// - first cycle may use any bank address
// - buffer program: E8h, count, n+1 words, D0h
// - OTP program: C0h then data word
// - clear status 50h, suspend B0h, resume D0h
// - factory passes of 32 words, exit outside block
// - status bit 7 high when controller ready
`timescale 1ns/1ps
module fcld_decoder (
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic [31:0]                      hrdata,
  output logic                             hresp,
  input  wire logic                        wp_n,
  input  wire logic                        pe_busy,
  input  wire logic [fcld_pkg::DATA_W-1:0] array_rdata,
  input  wire logic [fcld_pkg::DATA_W-1:0] query_rdata,
  output logic [fcld_pkg::ADDR_W-1:0]      flash_addr,
  output fcld_pkg::fcld_op_type            op
);

  typedef struct packed {
    logic                              wp_s1;   // pin sync stage 1
    logic                              wp_s2;   // pin sync stage 2
    logic                              wr_pend; // write data phase due
    logic                              rd_wait; // read wait state
    logic [7:0]                        ofs;     // latched byte offset
    logic [31:0]                       rdat;    // bus read data
    logic [fcld_pkg::ADDR_W-1:0]       fa;      // flash address latch
    fcld_pkg::fcld_cstate_type         cs;      // sequencer state
    logic                              reject;  // buffer target protected
    logic [4:0]                        cnt;     // buffer/factory counter
    logic [fcld_pkg::BLK_W-1:0]        fblk;    // factory start block
    logic [fcld_pkg::DATA_W-1:0]       cfg;     // configuration value
    fcld_pkg::fcld_rmode_type [fcld_pkg::NUM_BANK-1:0] modes; // per bank
    logic                              e_erase; // sticky erase error
    logic                              e_prog;  // sticky program error
    logic                              e_prot;  // sticky protection error
    fcld_pkg::fcld_op_type             op;      // launch to controller
  } fcld_state_type;

  fcld_state_type                r_reg;   // current state
  fcld_state_type                r_next;  // next state
  fcld_pkg::fcld_lock_type       lk_rd;   // lock bits of addressed block
  fcld_pkg::fcld_lock_type       lk_wd;   // lock bits to write
  logic                          lk_we;   // lock bit write strobe
  logic [fcld_pkg::BLK_W-1:0]    lk_ridx; // block read index

  // lock bits of the block that the address latch will point at
  assign lk_ridx = fcld_pkg::blk_of(r_next.fa);

  fcld_lock_mem u_lock_mem (
    .hclk    (hclk),
    .hresetn (hresetn),
    .we      (lk_we),
    .widx    (fcld_pkg::blk_of(r_reg.fa)),
    .wdata   (lk_wd),
    .ridx    (lk_ridx),
    .rdata   (lk_rd)
  );

  // status word as the controller and sticky errors show it
  function automatic logic [15:0] stat_word(input fcld_state_type s,
                                            input logic busy);
    stat_word = 16'h0000;
    stat_word[fcld_pkg::SR_READY_BIT] = ~busy;
    stat_word[fcld_pkg::SR_ERASE_ERR] = s.e_erase;
    stat_word[fcld_pkg::SR_PROG_ERR]  = s.e_prog;
    stat_word[fcld_pkg::SR_PROT_ERR]  = s.e_prot;
  endfunction

  // launch an operation toward the program/erase controller
  function automatic fcld_pkg::fcld_op_type mk_op(
      input fcld_pkg::fcld_opkind_type k,
      input logic [fcld_pkg::ADDR_W-1:0] a,
      input logic [fcld_pkg::DATA_W-1:0] d);
    mk_op.valid = 1'b1;
    mk_op.kind  = k;
    mk_op.addr  = a;
    mk_op.data  = d;
  endfunction

  // whole decoder: bus slave, read path and command sequencer
  always_comb begin
    logic [7:0]                     cmd;  // low byte of bus write
    logic [fcld_pkg::DATA_W-1:0]    wval; // full write_word_value
    logic [3:0]                     bank; // bank_select_addr field
    logic                           prot; // addressed block protected
    logic                           wp_low;
    logic [15:0]                    sig;  // signature read word
    r_next      = r_reg;
    cmd         = hwdata[7:0];
    wval        = hwdata[fcld_pkg::DATA_W-1:0];
    bank        = r_reg.fa[fcld_pkg::ADDR_W-1:fcld_pkg::BANK_LSB];
    wp_low      = ~r_reg.wp_s2;
    prot        = fcld_pkg::is_prot(lk_rd, wp_low);
    sig         = 16'h0000;
    lk_we       = 1'b0;
    lk_wd       = lk_rd;
    r_next.op   = '0;
    // write-protect pin, two flops before use
    r_next.wp_s1 = wp_n;
    r_next.wp_s2 = r_reg.wp_s1;

    // address phase: latch offset, start a write or a read wait
    r_next.wr_pend = 1'b0;
    if (hsel && hready && htrans[1]) begin
      r_next.ofs     = haddr[7:0];
      r_next.wr_pend = hwrite;
      r_next.rd_wait = ~hwrite;
    end

    // read wait cycle: build read data by offset; flash data follows the current bank mode
    if (r_reg.rd_wait) begin
      r_next.rd_wait = 1'b0;
      r_next.rdat    = 32'h0000_0000; // unmapped and write-only read zero
      if (r_reg.fa[fcld_pkg::BANK_LSB-1:0] == fcld_pkg::SIG_MFR_OFS)
        sig = fcld_pkg::SIG_MFR_CODE;
      else if (r_reg.fa[fcld_pkg::BANK_LSB-1:0] == fcld_pkg::SIG_DEV_OFS)
        sig = fcld_pkg::SIG_DEV_CODE;
      else if (r_reg.fa[fcld_pkg::PARM_LSB-1:0] == fcld_pkg::SIG_LOCK_OFS)
        sig = {14'h0000, lk_rd.down, lk_rd.locked};
      else if (r_reg.fa[fcld_pkg::BANK_LSB-1:0] == fcld_pkg::SIG_CFG_OFS)
        sig = r_reg.cfg;
      case (r_reg.ofs)
        fcld_pkg::REG_ADDR_OFS: begin
          r_next.rdat[fcld_pkg::ADDR_W-1:0] = r_reg.fa;
        end
        fcld_pkg::REG_RDATA_OFS: begin
          case (r_reg.modes[bank])
            fcld_pkg::RM_STAT:  r_next.rdat[15:0] = stat_word(r_reg, pe_busy);
            fcld_pkg::RM_SIG:   r_next.rdat[15:0] = sig;
            fcld_pkg::RM_QUERY: r_next.rdat[15:0] = query_rdata;
            default:            r_next.rdat[15:0] = array_rdata;
          endcase
        end
        fcld_pkg::REG_STAT_OFS: begin
          r_next.rdat = {10'h000, pe_busy, r_reg.wp_s2, r_reg.cs, r_reg.cfg};
        end
        default: begin
          r_next.rdat = 32'h0000_0000;
        end
      endcase
    end

    // write data phase
    if (r_reg.wr_pend && r_reg.ofs == fcld_pkg::REG_ADDR_OFS) begin
      r_next.fa = hwdata[fcld_pkg::ADDR_W-1:0];
    end else if (r_reg.wr_pend && r_reg.ofs == fcld_pkg::REG_WDATA_OFS) begin
      r_next.cs = fcld_pkg::CS_IDLE;
      case (r_reg.cs)
        // first cycle: any address within the bank serves
        fcld_pkg::CS_IDLE: begin
          case (cmd)
            fcld_pkg::CMD_READ_ARRAY: r_next.modes[bank] = fcld_pkg::RM_ARRAY;
            fcld_pkg::CMD_READ_STAT:  r_next.modes[bank] = fcld_pkg::RM_STAT;
            fcld_pkg::CMD_READ_SIG:   r_next.modes[bank] = fcld_pkg::RM_SIG;
            fcld_pkg::CMD_READ_QUERY: r_next.modes[bank] = fcld_pkg::RM_QUERY;
            fcld_pkg::CMD_CLR_STAT: begin
              r_next.e_erase = 1'b0;
              r_next.e_prog  = 1'b0;
              r_next.e_prot  = 1'b0;
              r_next.op = mk_op(fcld_pkg::OK_CLR_STATUS, r_reg.fa, wval);
            end
            fcld_pkg::CMD_SUSPEND:
              r_next.op = mk_op(fcld_pkg::OK_SUSPEND, r_reg.fa, wval);
            fcld_pkg::CMD_CONFIRM:
              r_next.op = mk_op(fcld_pkg::OK_RESUME, r_reg.fa, wval);
            fcld_pkg::CMD_ERASE:     r_next.cs = fcld_pkg::CS_ERASE_SU;
            fcld_pkg::CMD_PROG,
            fcld_pkg::CMD_PROG_ALT:  r_next.cs = fcld_pkg::CS_PROG_SU;
            fcld_pkg::CMD_SETUP_60:  r_next.cs = fcld_pkg::CS_SETUP60;
            fcld_pkg::CMD_OTP_PROG:  r_next.cs = fcld_pkg::CS_OTP_SU;
            fcld_pkg::CMD_FACT_PROG: r_next.cs = fcld_pkg::CS_FACT_SU;
            fcld_pkg::CMD_BLANK:     r_next.cs = fcld_pkg::CS_BLANK_SU;
            fcld_pkg::CMD_BUF_PROG: begin
              r_next.cs     = fcld_pkg::CS_BUF_CNT;
              r_next.reject = prot;
            end
            default: r_next.cs = fcld_pkg::CS_IDLE; // unknown code ignored
          endcase
        end
        fcld_pkg::CS_ERASE_SU: begin
          if (cmd != fcld_pkg::CMD_CONFIRM) begin
            r_next.e_erase = 1'b1; // bad confirm: sequence error
            r_next.e_prog  = 1'b1;
          end else if (prot) begin
            r_next.e_erase = 1'b1;
            r_next.e_prot  = 1'b1;
          end else begin
            r_next.op = mk_op(fcld_pkg::OK_ERASE, r_reg.fa, wval);
            r_next.modes[bank] = fcld_pkg::RM_STAT;
          end
        end
        fcld_pkg::CS_PROG_SU: begin
          if (prot) begin
            r_next.e_prog = 1'b1;
            r_next.e_prot = 1'b1;
          end else begin
            r_next.op = mk_op(fcld_pkg::OK_PROGRAM, r_reg.fa, wval);
            r_next.modes[bank] = fcld_pkg::RM_STAT;
          end
        end
        // second cycle of the 60h family
        fcld_pkg::CS_SETUP60: begin
          case (cmd)
            fcld_pkg::CMD_CFG_SET: begin
              r_next.cfg = r_reg.fa[15:0];
              r_next.modes[bank] = fcld_pkg::RM_ARRAY;
            end
            fcld_pkg::CMD_LOCK: begin
              lk_we = ~(lk_rd.down & wp_low);
              lk_wd.locked = 1'b1;
            end
            fcld_pkg::CMD_CONFIRM: begin
              lk_we = ~(lk_rd.down & wp_low);
              lk_wd.locked = 1'b0;
            end
            fcld_pkg::CMD_LOCKDOWN: begin
              lk_we = 1'b1;
              lk_wd.down = 1'b1;
            end
            default: begin
              r_next.e_erase = 1'b1; // bad second cycle
              r_next.e_prog  = 1'b1;
            end
          endcase
        end
        fcld_pkg::CS_OTP_SU: begin
          r_next.op = mk_op(fcld_pkg::OK_OTP_PROG, r_reg.fa, wval);
          r_next.modes[bank] = fcld_pkg::RM_STAT;
        end
        // buffer program: count, words, confirm
        fcld_pkg::CS_BUF_CNT: begin
          r_next.cnt = wval[4:0];
          r_next.cs  = fcld_pkg::CS_BUF_DATA;
          if (!r_reg.reject)
            r_next.op = mk_op(fcld_pkg::OK_BUF_START, r_reg.fa, wval);
        end
        fcld_pkg::CS_BUF_DATA: begin
          if (!r_reg.reject)
            r_next.op = mk_op(fcld_pkg::OK_BUF_WORD, r_reg.fa, wval);
          r_next.cs  = (r_reg.cnt == 5'h00) ? fcld_pkg::CS_BUF_CONF
                                            : fcld_pkg::CS_BUF_DATA;
          r_next.cnt = r_reg.cnt - 5'h01;
        end
        fcld_pkg::CS_BUF_CONF: begin
          if (r_reg.reject) begin
            r_next.e_prog = 1'b1; // protected target
            r_next.e_prot = 1'b1;
          end else if (cmd == fcld_pkg::CMD_CONFIRM) begin
            r_next.op = mk_op(fcld_pkg::OK_BUF_CONFIRM, r_reg.fa, wval);
            r_next.modes[bank] = fcld_pkg::RM_STAT;
          end else begin
            r_next.e_prog  = 1'b1; // missing confirm
            r_next.e_erase = 1'b1;
          end
        end
        // factory program: confirm at start address, then passes
        fcld_pkg::CS_FACT_SU: begin
          if (cmd != fcld_pkg::CMD_CONFIRM) begin
            r_next.e_prog  = 1'b1;
            r_next.e_erase = 1'b1;
          end else if (prot) begin
            r_next.e_prog = 1'b1;
            r_next.e_prot = 1'b1;
          end else begin
            r_next.op   = mk_op(fcld_pkg::OK_FACT_START, r_reg.fa, wval);
            r_next.fblk = fcld_pkg::blk_of(r_reg.fa);
            r_next.cnt  = 5'h00;
            r_next.cs   = fcld_pkg::CS_FACT_DATA;
            r_next.modes[bank] = fcld_pkg::RM_STAT;
          end
        end
        fcld_pkg::CS_FACT_DATA: begin
          if (fcld_pkg::blk_of(r_reg.fa) != r_reg.fblk) begin
            r_next.op = mk_op(fcld_pkg::OK_FACT_EXIT, r_reg.fa, wval);
          end else begin
            r_next.op  = mk_op(fcld_pkg::OK_FACT_WORD, r_reg.fa, wval);
            r_next.cs  = fcld_pkg::CS_FACT_DATA;
            r_next.cnt = (r_reg.cnt == 5'(fcld_pkg::FACT_PASS_WORDS - 1))
                         ? 5'h00 : r_reg.cnt + 5'h01;
          end
        end
        fcld_pkg::CS_BLANK_SU: begin
          if (cmd == fcld_pkg::CMD_BLANK_CONF)
            r_next.op = mk_op(fcld_pkg::OK_BLANK_CHECK, r_reg.fa, wval);
          else
            r_next.e_erase = 1'b1;
        end
        default: r_next.cs = fcld_pkg::CS_IDLE;
      endcase
    end
  end

  // single state register; reset returns array mode and default config
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg     <= '0;
      r_reg.cfg <= fcld_pkg::CFG_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  // bus answers: reads stall one cycle, response always okay
  assign hreadyout  = ~r_reg.rd_wait;
  assign hrdata     = r_reg.rdat;
  assign hresp      = 1'b0;
  assign flash_addr = r_reg.fa;
  assign op         = r_reg.op;

endmodule

/* File: fcld_pkg.sv */
// Purpose: shared constants, types and helpers of the flash command decoder
// Assumes: 23-bit word address, 16-bit data, 16 banks, 131 blocks
// Notes:   four small parameter blocks sit at the bottom of bank 0
package fcld_pkg;

  // geometry
  localparam int ADDR_W    = 23;  // flash word address width
  localparam int DATA_W    = 16;  // flash data width
  localparam int NUM_BLK   = 131; // 4 parameter + 127 main blocks
  localparam int NUM_BANK  = 16;  // 8-Mb banks
  localparam int BLK_W     = 8;   // block index width
  localparam int BANK_LSB  = 19;  // bank field is addr[22:19]
  localparam int MAIN_LSB  = 16;  // main block field is addr[22:16]
  localparam int PARM_LSB  = 14;  // parameter block field is addr[15:14]
  localparam logic [7:0] PARM_BLKS = 8'h04; // main blocks follow these

  // bus register offsets (byte addresses)
  localparam logic [7:0] REG_ADDR_OFS  = 8'h00; // flash address latch
  localparam logic [7:0] REG_WDATA_OFS = 8'h04; // write = flash bus write
  localparam logic [7:0] REG_RDATA_OFS = 8'h08; // read = flash bus read
  localparam logic [7:0] REG_STAT_OFS  = 8'h0C; // decoder state

  // command codes
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_STAT  = 8'h70;
  localparam logic [7:0] CMD_READ_SIG   = 8'h90;
  localparam logic [7:0] CMD_READ_QUERY = 8'h98;
  localparam logic [7:0] CMD_CLR_STAT   = 8'h50;
  localparam logic [7:0] CMD_ERASE      = 8'h20;
  localparam logic [7:0] CMD_PROG       = 8'h40;
  localparam logic [7:0] CMD_PROG_ALT   = 8'h10;
  localparam logic [7:0] CMD_BUF_PROG   = 8'hE8;
  localparam logic [7:0] CMD_CONFIRM    = 8'hD0; // also resume, unlock
  localparam logic [7:0] CMD_SUSPEND    = 8'hB0;
  localparam logic [7:0] CMD_OTP_PROG   = 8'hC0;
  localparam logic [7:0] CMD_SETUP_60   = 8'h60;
  localparam logic [7:0] CMD_CFG_SET    = 8'h03;
  localparam logic [7:0] CMD_LOCK       = 8'h01;
  localparam logic [7:0] CMD_LOCKDOWN   = 8'h2F;
  localparam logic [7:0] CMD_FACT_PROG  = 8'h80;
  localparam logic [7:0] CMD_BLANK      = 8'hBC;
  localparam logic [7:0] CMD_BLANK_CONF = 8'hCB;

  // status word bit positions
  localparam int SR_READY_BIT  = 7; // controller_ready_bit
  localparam int SR_ERASE_ERR  = 5;
  localparam int SR_PROG_ERR   = 4;
  localparam int SR_PROT_ERR   = 1;

  // signature offsets and values
  localparam logic [18:0] SIG_MFR_OFS  = 19'h0_0000; // from bank start
  localparam logic [18:0] SIG_DEV_OFS  = 19'h0_0001; // from bank start
  localparam logic [18:0] SIG_CFG_OFS  = 19'h0_0005; // from bank start
  localparam logic [13:0] SIG_LOCK_OFS = 14'h0002;   // from block start
  localparam logic [15:0] SIG_MFR_CODE = 16'h00A5;   // arbitrary value
  localparam logic [15:0] SIG_DEV_CODE = 16'h005A;   // arbitrary value

  localparam logic [15:0] CFG_RESET       = 16'h0000; // config after reset
  localparam int          FACT_PASS_WORDS = 32;       // words per pass

  // per-bank read mode
  typedef enum logic [1:0] {
    RM_ARRAY = 2'b00,
    RM_STAT  = 2'b01,
    RM_SIG   = 2'b10,
    RM_QUERY = 2'b11
  } fcld_rmode_type;

  // command sequencer states, gray along setup -> data -> confirm
  typedef enum logic [3:0] {
    CS_IDLE      = 4'b0000,
    CS_SETUP60   = 4'b0001,
    CS_ERASE_SU  = 4'b0011,
    CS_PROG_SU   = 4'b0010,
    CS_OTP_SU    = 4'b0110,
    CS_BUF_CNT   = 4'b0111,
    CS_BUF_DATA  = 4'b0101,
    CS_BUF_CONF  = 4'b0100,
    CS_FACT_SU   = 4'b1100,
    CS_FACT_DATA = 4'b1101,
    CS_BLANK_SU  = 4'b1111
  } fcld_cstate_type;

  // operations handed to the program/erase controller
  typedef enum logic [3:0] {
    OK_NONE, OK_ERASE, OK_PROGRAM, OK_BUF_START, OK_BUF_WORD,
    OK_BUF_CONFIRM, OK_OTP_PROG, OK_FACT_START, OK_FACT_WORD,
    OK_FACT_EXIT, OK_SUSPEND, OK_RESUME, OK_CLR_STATUS, OK_BLANK_CHECK
  } fcld_opkind_type;

  typedef struct packed {
    logic                valid; // one-cycle launch pulse
    fcld_opkind_type     kind;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
  } fcld_op_type;

  typedef struct packed {
    logic locked;
    logic down;
  } fcld_lock_type;

  // block index of a word address
  function automatic logic [BLK_W-1:0] blk_of(input logic [ADDR_W-1:0] a);
    if (a[ADDR_W-1:MAIN_LSB] == 7'h00)
      blk_of = {6'h00, a[MAIN_LSB-1:PARM_LSB]};
    else
      blk_of = {1'b0, a[ADDR_W-1:MAIN_LSB]} + PARM_BLKS - 8'h01;
  endfunction

  // block refuses program/erase
  function automatic logic is_prot(input fcld_lock_type e,
                                   input logic wp_low);
    is_prot = e.locked | (e.down & wp_low);
  endfunction

endpackage

/* File: fcld_lock_mem.sv */
// Purpose: per-block lock and lock-down bits with registered read port
// Assumes: one write per cycle, write-through to the read register
// Notes:   reset leaves every block locked and none locked down
`timescale 1ns/1ps
module fcld_lock_mem (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       we,
  input  wire logic [fcld_pkg::BLK_W-1:0] widx,
  input  wire fcld_pkg::fcld_lock_type    wdata,
  input  wire logic [fcld_pkg::BLK_W-1:0] ridx,
  output fcld_pkg::fcld_lock_type         rdata
);

  typedef struct packed {
    logic [fcld_pkg::NUM_BLK-1:0] locks; // locked attribute per block
    logic [fcld_pkg::NUM_BLK-1:0] downs; // locked-down attribute
    fcld_pkg::fcld_lock_type      rd;    // registered read data
  } fcld_mem_state_type;

  fcld_mem_state_type r_reg;  // current state
  fcld_mem_state_type r_next; // next state

  // write then read; a write to the read block is passed straight through
  always_comb begin
    r_next = r_reg;
    if (we) begin
      r_next.locks[widx] = wdata.locked;
      r_next.downs[widx] = wdata.down;
    end
    r_next.rd.locked = r_next.locks[ridx];
    r_next.rd.down   = r_next.downs[ridx];
  end

  // lock bits come up set, lock-down bits come up clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg.locks     <= '1;
      r_reg.downs     <= '0;
      r_reg.rd.locked <= 1'b1;
      r_reg.rd.down   <= 1'b0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign rdata = r_reg.rd;

endmodule

/* File: fcld_decoder_chk_sva.sv */
// Purpose: bus timing and op launch checks of the decoder
// Assumes: one slave, hready tied to hreadyout
// Notes:   bound to every decoder instance
`timescale 1ns/1ps
module fcld_decoder_chk (
  input wire logic                        hclk,
  input wire logic                        hresetn,
  input wire logic                        hsel,
  input wire logic [31:0]                 haddr,
  input wire logic [1:0]                  htrans,
  input wire logic                        hwrite,
  input wire logic [31:0]                 hwdata,
  input wire logic                        hready,
  input wire logic                        hreadyout,
  input wire logic [31:0]                 hrdata,
  input wire logic                        hresp,
  input wire logic [fcld_pkg::ADDR_W-1:0] flash_addr,
  input wire fcld_pkg::fcld_op_type       op
);
  logic tk;     // transfer taken at this edge
  logic wd_reg; // data phase of a flash bus write
  assign tk = hsel & hready & htrans[1];
  // remember flash writes so op pulses can be traced to them
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) wd_reg <= 1'b0;
    else wd_reg <= tk & hwrite & (haddr[7:0] == 8'h04);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  chk_read_wait: assert property (tk & !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  chk_write_fast: assert property (tk & hwrite |=> hreadyout)
    else $error("write stalled");
  chk_op_pulse: assert property (op.valid |=> !op.valid)
    else $error("op pulse too long");
  chk_op_cause: assert property (op.valid |-> $past(wd_reg))
    else $error("op without flash write");
  chk_op_addr: assert property (op.valid |-> op.addr == flash_addr)
    else $error("op address wrong");
  chk_op_data: assert property (op.valid |-> op.data == $past(hwdata[15:0]))
    else $error("op data wrong");
  chk_addr_latch: assert property (tk & hwrite & (haddr[7:0] == 8'h00) ##1 1
    |=> flash_addr == $past(hwdata[22:0]))
    else $error("address latch wrong");
  chk_rdata_hold: assert property (!$stable(hrdata) |-> !$past(hreadyout))
    else $error("read data moved");
endmodule
bind fcld_decoder fcld_decoder_chk u_chk (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hrdata, .hresp,
  .flash_addr, .op);

/* File: fcld_pe_model.sv */
// Purpose: program/erase controller and array stand-in
// Assumes: array and query words are fixed functions of the address
// Notes:   erase holds busy long enough to read status while busy
`timescale 1ns/1ps
module fcld_pe_model (
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  input  wire logic [fcld_pkg::ADDR_W-1:0] flash_addr,
  input  wire fcld_pkg::fcld_op_type       op,
  output logic                             pe_busy,
  output logic [fcld_pkg::DATA_W-1:0]      array_rdata,
  output logic [fcld_pkg::DATA_W-1:0]      query_rdata
);
  logic [4:0] cnt_reg; // busy cycles left
  // an erase launch occupies the controller for twenty cycles
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) cnt_reg <= 5'h00;
    else if (op.valid && op.kind == fcld_pkg::OK_ERASE) cnt_reg <= 5'h14;
    else if (cnt_reg != 5'h00) cnt_reg <= cnt_reg - 5'h01;
  assign pe_busy     = (cnt_reg != 5'h00);
  assign array_rdata = flash_addr[15:0] ^ 16'h5a5a;
  assign query_rdata = ~flash_addr[15:0];
endmodule

/* File: fcld_decoder_test.sv */
// Purpose: self-checking bench of the decoder over AHB-Lite
// Assumes: seed 55, one master, hready tied to hreadyout
// Notes:   expected reads and ops are queued, a monitor compares
`timescale 1ns/1ps
module fcld_decoder_test;
  localparam logic [22:0] BLK = 23'h01_0000; // first main block, bank 0
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic wp_n = 1'b1, rd_dp = 1'b0, hreadyout, hresp, pe_busy;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
  logic [1:0]  htrans = 2'b00;
  logic [15:0] array_rdata, query_rdata;
  logic [22:0] flash_addr, ca;
  fcld_pkg::fcld_op_type op;
  logic [31:0] exp_rd[$]; // expected read words
  logic [26:0] exp_op[$]; // expected {kind, addr}
  int n_errors = 0;
  int total_checks = 0;
  always #4 hclk = ~hclk;
  fcld_decoder uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'b010), .hwdata, .hready(hreadyout), .hreadyout, .hrdata,
    .hresp, .wp_n, .pe_busy, .array_rdata, .query_rdata, .flash_addr, .op);
  fcld_pe_model pe (.hclk, .hresetn, .flash_addr, .op, .pe_busy,
    .array_rdata, .query_rdata);
  task automatic cmp(input string nm, input logic [31:0] e, s);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one single transfer; both phases wait for hready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    for (int p = 0; p < 2; p++) begin
      k = 0;
      do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 40);
      if (hreadyout !== 1'b1) begin n_errors++; end_of_test(); end
      htrans <= 2'b00;
      hwdata <= d;
    end
  endtask
  task automatic fw(input logic [22:0] a, input logic [7:0] c);
    xfer(1'b1, 8'h00, {9'h000, a});
    xfer(1'b1, 8'h04, {24'h00_0000, c});
  endtask
  task automatic rd(input logic [22:0] a, input logic [15:0] e);
    xfer(1'b1, 8'h00, {9'h000, a});
    exp_rd.push_back({16'h0000, e});
    xfer(1'b0, 8'h08, 32'h0000_0000);
  endtask
  task automatic opx(input fcld_pkg::fcld_opkind_type k, input logic [22:0] a);
    exp_op.push_back({k, a});
  endtask
  // monitor: a finished read or an op pulse takes the oldest note
  always @(posedge hclk) begin
    if (rd_dp && hreadyout)
      cmp("hrdata", exp_rd.size() ? exp_rd.pop_front() : 32'hdead_beef,
          hrdata);
    if (op.valid === 1'b1)
      cmp("op", exp_op.size() ? exp_op.pop_front() : 27'h0,
          {op.kind, op.addr});
    rd_dp <= (hsel & hreadyout & htrans[1]) ? !hwrite : (rd_dp & !hreadyout);
  end
  initial begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    end_of_test();
  end
  initial begin
    void'($urandom(55));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    fw(BLK, 8'h90); rd(BLK + 23'h2, 16'h0001);
    fw(BLK, 8'h98); rd(BLK, ~BLK[15:0]);
    fw(BLK, 8'hff); rd(BLK, BLK[15:0] ^ 16'h5a5a);
    fw(BLK, 8'h20); fw(BLK, 8'hd0); fw(BLK, 8'h70);
    rd(BLK, 16'h00a2);
    opx(fcld_pkg::OK_CLR_STATUS, BLK); fw(BLK, 8'h50);
    rd(BLK, 16'h0080);
    fw(BLK, 8'h60); fw(BLK, 8'hd0);
    opx(fcld_pkg::OK_ERASE, BLK); fw(BLK, 8'h20); fw(BLK, 8'hd0);
    rd(BLK, 16'h0000);
    repeat (24) @(posedge hclk);
    rd(BLK, 16'h0080);
    wp_n <= 1'b0;
    fw(BLK, 8'h60); fw(BLK, 8'h2f); fw(BLK, 8'h60); fw(BLK, 8'h01);
    fw(BLK, 8'h90); rd(BLK + 23'h2, 16'h0002);
    fw(BLK, 8'h20); fw(BLK, 8'hd0); fw(BLK, 8'h70);
    rd(BLK, 16'h00a2);
    opx(fcld_pkg::OK_CLR_STATUS, BLK); fw(BLK, 8'h50);
    wp_n <= 1'b1;
    opx(fcld_pkg::OK_ERASE, BLK); fw(BLK, 8'h20); fw(BLK, 8'hd0);
    opx(fcld_pkg::OK_SUSPEND, BLK); fw(BLK, 8'hb0);
    opx(fcld_pkg::OK_RESUME, BLK); fw(BLK, 8'hd0);
    ca = 23'($urandom());
    ca[22:19] = 4'h0;
    fw(ca, 8'h60); fw(ca, 8'h03);
    rd(ca, ca[15:0] ^ 16'h5a5a);
    fw(23'h0, 8'h90); rd(23'h5, ca[15:0]);
    opx(fcld_pkg::OK_PROGRAM, BLK); fw(BLK, 8'h40); fw(BLK, 8'h55);
    opx(fcld_pkg::OK_BUF_START, BLK); fw(BLK, 8'he8); fw(BLK, 8'h00);
    opx(fcld_pkg::OK_BUF_WORD, BLK); fw(BLK, 8'h33);
    opx(fcld_pkg::OK_BUF_CONFIRM, BLK); fw(BLK, 8'hd0);
    opx(fcld_pkg::OK_OTP_PROG, BLK); fw(BLK, 8'hc0); fw(BLK, 8'h12);
    exp_rd.push_back(32'h0000_0000);
    xfer(1'b0, 8'h10, 32'h0000_0000);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    fw(BLK, 8'h90); rd(BLK + 23'h2, 16'h0001);
    @(posedge hclk);
    cmp("queues", 32'h0, exp_rd.size() + exp_op.size());
    end_of_test();
  end
endmodule
